/* File: core/sinc3_pkg.sv */
// Operation
// - The filter is a third-order sinc, one order above the second-order modulator.
// - The filter realises H(z) = ((1/R)(1 - z^-R)/(1 - z^-1))^3 with R the decimation ratio.
// - One output word is produced every decimation_ratio modulator clock cycles.
// - The full result is 3 x log2(ratio) bits wide; above ratio 32 only its upper sixteen bits are returned, at 32 all 15 with a zero below.
// - At a 10 MHz modulator clock the raw widths are 15, 18, 21, 24 and 27 bits for ratios 32 to 512.
// - The -3 dB corner of the response lies at 0.262 times the output word rate.
// - The incoming stream bit is taken at the falling edge of the modulator clock.
// - A 16-bit decimation selection covers ratios from 32 up to 4096.
// - Each stream bit becomes a 37-bit operand, zero for a low bit and one for a high bit.
// - Three cascaded 37-bit integrators update on every falling modulator edge and clear on reset.
// - A 16-bit sample counter steps on every falling edge, wraps after ratio minus one and clears on reset.
// - The word strobe rises at count half ratio minus one, falls at ratio minus one, and is low after reset.
// - Three cascaded 37-bit differentiators, each subtracting its one-word-delayed input, run on each word strobe fall.
// - The result word is a ratio-dependent slice of the last differentiator, positive full scale saturates to all ones, unknown ratios use the 256 slice.
// - The word-valid output pulses for one mclk_in cycle per word at the half-ratio point and is re-armed at the end of the count.
package sinc3_pkg;

	localparam int ACC_W   = 37;
	localparam int RATIO_W = 16;
	localparam int WORD_W  = 16;
	localparam int SLICE_W = 17;
	localparam int SHIFT_W = 6;
	localparam int FIFO_DEPTH = 16;

	localparam logic [ACC_W-1:0]   ACC_ZERO   = 37'h0;
	localparam logic [ACC_W-1:0]   ACC_ONE    = 37'h1;
	localparam logic [RATIO_W-1:0] COUNT_ZERO = 16'h0;
	localparam logic [RATIO_W-1:0] COUNT_STEP = 16'h1;
	localparam logic [WORD_W-1:0]  WORD_ZERO  = 16'h0;
	localparam logic [WORD_W-1:0]  WORD_FULL  = 16'hffff;
	localparam logic [SLICE_W-1:0] SAT_CODE   = 17'h10000;

	localparam logic [RATIO_W-1:0] RATIO_32   = 16'h0020;
	localparam logic [RATIO_W-1:0] RATIO_64   = 16'h0040;
	localparam logic [RATIO_W-1:0] RATIO_128  = 16'h0080;
	localparam logic [RATIO_W-1:0] RATIO_256  = 16'h0100;
	localparam logic [RATIO_W-1:0] RATIO_512  = 16'h0200;
	localparam logic [RATIO_W-1:0] RATIO_1024 = 16'h0400;
	localparam logic [RATIO_W-1:0] RATIO_2048 = 16'h0800;
	localparam logic [RATIO_W-1:0] RATIO_4096 = 16'h1000;

	// Shift of the result window over the difference value with one zero appended below.
	localparam logic [SHIFT_W-1:0] SHIFT_32   = 6'h00;
	localparam logic [SHIFT_W-1:0] SHIFT_64   = 6'h03;
	localparam logic [SHIFT_W-1:0] SHIFT_128  = 6'h06;
	localparam logic [SHIFT_W-1:0] SHIFT_256  = 6'h09;
	localparam logic [SHIFT_W-1:0] SHIFT_512  = 6'h0c;
	localparam logic [SHIFT_W-1:0] SHIFT_1024 = 6'h0f;
	localparam logic [SHIFT_W-1:0] SHIFT_2048 = 6'h12;
	localparam logic [SHIFT_W-1:0] SHIFT_4096 = 6'h15;

	typedef enum logic {
		ARMED = 1'b0,
		FIRED = 1'b1
	} arm_type;

	function automatic logic [SHIFT_W-1:0] slice_shift(input logic [RATIO_W-1:0] ratio);
		case (ratio)
			RATIO_32:   slice_shift = SHIFT_32;
			RATIO_64:   slice_shift = SHIFT_64;
			RATIO_128:  slice_shift = SHIFT_128;
			RATIO_256:  slice_shift = SHIFT_256;
			RATIO_512:  slice_shift = SHIFT_512;
			RATIO_1024: slice_shift = SHIFT_1024;
			RATIO_2048: slice_shift = SHIFT_2048;
			RATIO_4096: slice_shift = SHIFT_4096;
			default:    slice_shift = SHIFT_256;
		endcase
	endfunction

	function automatic logic [SLICE_W-1:0] window(input logic [ACC_W-1:0] diff,
		input logic [RATIO_W-1:0] ratio);
		logic [ACC_W:0] ext;
		ext = {diff, 1'b0} >> slice_shift(ratio);
		window = ext[SLICE_W-1:0];
	endfunction

	function automatic logic [WORD_W-1:0] result_word(input logic [ACC_W-1:0] diff,
		input logic [RATIO_W-1:0] ratio);
		logic [SLICE_W-1:0] win;
		win = window(diff, ratio);
		result_word = (win == SAT_CODE) ? WORD_FULL : win[WORD_W-1:0];
	endfunction

endpackage

/* File: core/sample_fifo.sv */
`timescale 1ns/100ps
module sample_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
)
(
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0]   FILL_FULL = DEPTH[PTR_W:0];
	localparam logic [PTR_W-1:0] PTR_LAST  = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_q;
	logic [PTR_W-1:0] wr_d;
	logic [PTR_W-1:0] rd_q;
	logic [PTR_W-1:0] rd_d;
	logic [PTR_W:0]   fill_q;
	logic [PTR_W:0]   fill_d;
	logic             push;
	logic             pop;

	assign in_ready_out  = (fill_q != FILL_FULL);
	assign out_valid_out = (fill_q != '0);
	assign out_data_out  = mem[rd_q];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	always_comb
	begin
		wr_d   = wr_q;
		rd_d   = rd_q;
		fill_d = fill_q;
		if (push)
			wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
		if (pop)
			rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
		if (push && !pop)
			fill_d = fill_q + 1'b1;
		else if (pop && !push)
			fill_d = fill_q - 1'b1;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wr_q   <= '0;
			rd_q   <= '0;
			fill_q <= '0;
		end
		else
		begin
			wr_q   <= wr_d;
			rd_q   <= rd_d;
			fill_q <= fill_d;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wr_q] <= in_data_in;
	end
endmodule // sample_fifo

/* File: core/sinc3_decimation_filter.sv */
`timescale 1ns/100ps
module sinc3_decimation_filter
	import sinc3_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               nrst_in,
	input  wire logic               filter_sample_clock_in,
	input  wire logic               bitstream_in,
	input  wire logic [RATIO_W-1:0] decimation_ratio_in,
	output logic      [WORD_W-1:0]  sample_data_out,
	output logic                    sample_valid_out,
	input  wire logic               sample_ready_in,
	output logic                    word_valid_out,
	output logic                    word_strobe_out,
	output logic                    fifo_space_out,
	output logic                    overrun_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for the modulator clock and stream, falling edge detection.

	logic clk_meta_q;
	logic clk_meta_d;
	logic clk_sync_q;
	logic clk_sync_d;
	logic clk_prev_q;
	logic clk_prev_d;
	logic bit_meta_q;
	logic bit_meta_d;
	logic bit_sync_q;
	logic bit_sync_d;
	logic sample_tick;

	always_comb
	begin
		clk_meta_d = filter_sample_clock_in;
		clk_sync_d = clk_meta_q;
		clk_prev_d = clk_sync_q;
		bit_meta_d = bitstream_in;
		bit_sync_d = bit_meta_q;
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			clk_meta_q <= 1'b0;
			clk_sync_q <= 1'b0;
			clk_prev_q <= 1'b0;
			bit_meta_q <= 1'b0;
			bit_sync_q <= 1'b0;
		end
		else
		begin
			clk_meta_q <= clk_meta_d;
			clk_sync_q <= clk_sync_d;
			clk_prev_q <= clk_prev_d;
			bit_meta_q <= bit_meta_d;
			bit_sync_q <= bit_sync_d;
		end
	end

	// The stream bit is delayed as much as the clock, so it is taken mid-period.
	assign sample_tick = clk_prev_q && !clk_sync_q;

	////////////////////////////////////////////////////////////////////////////////
	// Integrators, sample counter, word strobe and word-valid arming.

	logic [ACC_W-1:0]   input_operand;
	logic [ACC_W-1:0]   integrator_stage_one_q;
	logic [ACC_W-1:0]   integrator_stage_one_d;
	logic [ACC_W-1:0]   integrator_stage_two_q;
	logic [ACC_W-1:0]   integrator_stage_two_d;
	logic [ACC_W-1:0]   integrator_stage_three_q;
	logic [ACC_W-1:0]   integrator_stage_three_d;
	logic [RATIO_W-1:0] count_q;
	logic [RATIO_W-1:0] count_d;
	logic [RATIO_W-1:0] count_last;
	logic [RATIO_W-1:0] count_half;
	logic               strobe_q;
	logic               strobe_d;
	arm_type            arm_q;
	arm_type            arm_d;
	logic               word_valid_q;
	logic               word_valid_d;

	assign input_operand = bit_sync_q ? ACC_ONE : ACC_ZERO;
	assign count_last = decimation_ratio_in - COUNT_STEP;
	assign count_half = (decimation_ratio_in >> 1) - COUNT_STEP;

	always_comb
	begin
		integrator_stage_one_d   = integrator_stage_one_q;
		integrator_stage_two_d   = integrator_stage_two_q;
		integrator_stage_three_d = integrator_stage_three_q;
		count_d      = count_q;
		strobe_d     = strobe_q;
		arm_d        = arm_q;
		word_valid_d = 1'b0;
		if (sample_tick)
		begin
			integrator_stage_one_d   = integrator_stage_one_q + input_operand;
			integrator_stage_two_d   = integrator_stage_two_q + integrator_stage_one_q;
			integrator_stage_three_d = integrator_stage_three_q + integrator_stage_two_q;
			if (count_q == count_last)
				count_d = COUNT_ZERO;
			else
				count_d = count_q + COUNT_STEP;
			if (count_q == count_half)
				strobe_d = 1'b1;
			else if (count_q == count_last)
				strobe_d = 1'b0;
			case (arm_q)
				ARMED:
				begin
					if (count_q == count_half)
					begin
						word_valid_d = 1'b1;
						arm_d = FIRED;
					end
				end
				FIRED:
				begin
					if (count_q == count_last)
						arm_d = ARMED;
				end
				default:
					arm_d = ARMED;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			integrator_stage_one_q   <= ACC_ZERO;
			integrator_stage_two_q   <= ACC_ZERO;
			integrator_stage_three_q <= ACC_ZERO;
			count_q      <= COUNT_ZERO;
			strobe_q     <= 1'b0;
			arm_q        <= ARMED;
			word_valid_q <= 1'b0;
		end
		else
		begin
			integrator_stage_one_q   <= integrator_stage_one_d;
			integrator_stage_two_q   <= integrator_stage_two_d;
			integrator_stage_three_q <= integrator_stage_three_d;
			count_q      <= count_d;
			strobe_q     <= strobe_d;
			arm_q        <= arm_d;
			word_valid_q <= word_valid_d;
		end
	end

	assign word_valid_out  = word_valid_q;
	assign word_strobe_out = strobe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Differentiators and result word, run once per word at the strobe fall.

	logic             strobe_prev_q;
	logic             word_tick;
	logic [ACC_W-1:0] integrator_delay_q;
	logic [ACC_W-1:0] integrator_delay_d;
	logic [ACC_W-1:0] differentiator_stage_one_q;
	logic [ACC_W-1:0] differentiator_stage_one_d;
	logic [ACC_W-1:0] differentiator_stage_two_q;
	logic [ACC_W-1:0] differentiator_stage_two_d;
	logic [ACC_W-1:0] differentiator_stage_three_q;
	logic [ACC_W-1:0] differentiator_stage_three_d;
	logic [ACC_W-1:0] diff_one_delay_q;
	logic [ACC_W-1:0] diff_one_delay_d;
	logic [ACC_W-1:0] diff_two_delay_q;
	logic [ACC_W-1:0] diff_two_delay_d;
	logic [WORD_W-1:0] result_d;

	assign word_tick = strobe_prev_q && !strobe_q;

	always_comb
	begin
		integrator_delay_d           = integrator_delay_q;
		differentiator_stage_one_d   = differentiator_stage_one_q;
		differentiator_stage_two_d   = differentiator_stage_two_q;
		differentiator_stage_three_d = differentiator_stage_three_q;
		diff_one_delay_d = diff_one_delay_q;
		diff_two_delay_d = diff_two_delay_q;
		if (word_tick)
		begin
			differentiator_stage_one_d   = integrator_stage_three_q - integrator_delay_q;
			differentiator_stage_two_d   = differentiator_stage_one_q - diff_one_delay_q;
			differentiator_stage_three_d = differentiator_stage_two_q - diff_two_delay_q;
			integrator_delay_d = integrator_stage_three_q;
			diff_one_delay_d   = differentiator_stage_one_q;
			diff_two_delay_d   = differentiator_stage_two_q;
		end
	end

	// The word carries the third stage as it stood before this update, one word of latency.
	assign result_d = result_word(differentiator_stage_three_q, decimation_ratio_in);

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			strobe_prev_q                <= 1'b0;
			integrator_delay_q           <= ACC_ZERO;
			differentiator_stage_one_q   <= ACC_ZERO;
			differentiator_stage_two_q   <= ACC_ZERO;
			differentiator_stage_three_q <= ACC_ZERO;
			diff_one_delay_q             <= ACC_ZERO;
			diff_two_delay_q             <= ACC_ZERO;
		end
		else
		begin
			strobe_prev_q                <= strobe_q;
			integrator_delay_q           <= integrator_delay_d;
			differentiator_stage_one_q   <= differentiator_stage_one_d;
			differentiator_stage_two_q   <= differentiator_stage_two_d;
			differentiator_stage_three_q <= differentiator_stage_three_d;
			diff_one_delay_q             <= diff_one_delay_d;
			diff_two_delay_q             <= diff_two_delay_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Word buffer and registered output stage toward the consumer.

	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic [WORD_W-1:0] fifo_out_data;
	logic              fifo_pop;
	logic              out_valid_q;
	logic              out_valid_d;
	logic [WORD_W-1:0] out_data_q;
	logic [WORD_W-1:0] out_data_d;
	logic              space_q;
	logic              space_d;
	logic              overrun_q;
	logic              overrun_d;

	sample_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) word_buffer (
		.clk_in        (mclk_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (word_tick),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (result_d),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_out_data)
	);

	assign fifo_pop = fifo_out_valid && (!out_valid_q || sample_ready_in);

	always_comb
	begin
		out_valid_d = out_valid_q;
		out_data_d  = out_data_q;
		if (fifo_pop)
		begin
			out_valid_d = 1'b1;
			out_data_d  = fifo_out_data;
		end
		else if (sample_ready_in)
			out_valid_d = 1'b0;
		space_d = fifo_in_ready;
		// A word that finds the buffer full is dropped; the stream cannot be stalled.
		overrun_d = overrun_q || (word_tick && !fifo_in_ready);
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			out_valid_q <= 1'b0;
			out_data_q  <= WORD_ZERO;
			space_q     <= 1'b1;
			overrun_q   <= 1'b0;
		end
		else
		begin
			out_valid_q <= out_valid_d;
			out_data_q  <= out_data_d;
			space_q     <= space_d;
			overrun_q   <= overrun_d;
		end
	end

	assign sample_valid_out = out_valid_q;
	assign sample_data_out  = out_data_q;
	assign fifo_space_out   = space_q;
	assign overrun_out      = overrun_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);

	a_operand_map: assert property (input_operand == {36'h0, bit_sync_q})
		else $error("operand does not follow the stream bit");
	a_int_first_add: assert property (sample_tick |=>
		integrator_stage_one_q == $past(integrator_stage_one_q) + $past(input_operand))
		else $error("first integrator did not add the operand");
	a_int_chain_add: assert property (sample_tick |=>
		integrator_stage_three_q == $past(integrator_stage_three_q) + $past(integrator_stage_two_q))
		else $error("third integrator did not add the second");
	a_int_hold_idle: assert property (!sample_tick |=> $stable(integrator_stage_one_q))
		else $error("integrator moved without a modulator edge");
	a_count_wrap_end: assert property (sample_tick && count_q == count_last |=>
		count_q == COUNT_ZERO)
		else $error("counter did not wrap at ratio minus one");
	a_count_step_one: assert property (sample_tick && count_q != count_last |=>
		count_q == $past(count_q) + COUNT_STEP)
		else $error("counter did not step by one");
	a_strobe_rise_half: assert property (sample_tick && count_q == count_half |=> strobe_q)
		else $error("strobe did not rise at half ratio");
	a_strobe_fall_end: assert property (sample_tick && count_q == count_last |=> !strobe_q)
		else $error("strobe did not fall at ratio end");
	a_valid_one_pulse: assert property (word_valid_out |=> !word_valid_out)
		else $error("word valid longer than one cycle");
	a_valid_at_half: assert property (word_valid_out |-> strobe_q && arm_q == FIRED)
		else $error("word valid without strobe rise");
	a_diff_first_stage: assert property (word_tick |=>
		differentiator_stage_one_q == $past(integrator_stage_three_q) - $past(integrator_delay_q))
		else $error("first differentiator wrong");
	a_sat_full_scale: assert property (word_tick && fifo_in_ready && fifo_out_valid == 1'b0 &&
		!out_valid_q && window(differentiator_stage_three_q, decimation_ratio_in) == SAT_CODE
		|=> ##1 sample_data_out == WORD_FULL)
		else $error("full scale did not saturate");

	c_word_out: cover property (sample_valid_out && sample_ready_in);
	c_saturated: cover property (word_tick && result_d == WORD_FULL);
	c_overrun: cover property (!overrun_out ##1 overrun_out);
	c_ratio_small: cover property (word_valid_out && decimation_ratio_in == RATIO_32);

	// The ratio input is read live; change it only under reset.
endmodule // sinc3_decimation_filter

/* File: tb/modulator_model.sv */
`timescale 1ns/100ps
module modulator_model
(
	input  wire logic [1:0] pattern_in,
	output logic            modulator_clock_out,
	output logic            bitstream_out
);

	logic toggle_q;

	////////////////////////////////////////////////////////////////////////////////
	// The modulator clock runs free at 64 ns with a phase unrelated to the system clock.
	// The stream bit changes on the rising edge so it is settled around the falling edge.
	initial
	begin
		modulator_clock_out = 1'b1;
		bitstream_out = 1'b0;
		toggle_q = 1'b0;
		#5.3;
		forever
		begin
			#32 modulator_clock_out = 1'b0;
			#32 modulator_clock_out = 1'b1;
			toggle_q = ~toggle_q;
			case (pattern_in)
				2'h0: bitstream_out = 1'b0;
				2'h1: bitstream_out = 1'b1;
				default: bitstream_out = toggle_q;
			endcase
		end
	end

endmodule // modulator_model

/* File: tb/sinc3_decimation_filter_tb.sv */
`timescale 1ns/100ps
module sinc3_decimation_filter_tb
	import sinc3_pkg::*;
;

	logic               mclk_in = 1'b0;
	logic               nrst_in;
	logic               filter_sample_clock_in;
	logic               bitstream_in;
	logic [RATIO_W-1:0] decimation_ratio_in;
	logic [WORD_W-1:0]  sample_data_out;
	logic               sample_valid_out;
	logic               sample_ready_in;
	logic               word_valid_out;
	logic               word_strobe_out;
	logic               fifo_space_out;
	logic               overrun_out;
	logic [1:0]         pattern;
	int                 n_mismatch;
	int                 tests_run;

	always #4 mclk_in = ~mclk_in;

	modulator_model u_mod
	(
		.pattern_in          (pattern),
		.modulator_clock_out (filter_sample_clock_in),
		.bitstream_out       (bitstream_in)
	);

	sinc3_decimation_filter u_dut
	(
		.mclk_in                (mclk_in),
		.nrst_in                (nrst_in),
		.filter_sample_clock_in (filter_sample_clock_in),
		.bitstream_in           (bitstream_in),
		.decimation_ratio_in    (decimation_ratio_in),
		.sample_data_out        (sample_data_out),
		.sample_valid_out       (sample_valid_out),
		.sample_ready_in        (sample_ready_in),
		.word_valid_out         (word_valid_out),
		.word_strobe_out        (word_strobe_out),
		.fifo_space_out         (fifo_space_out),
		.overrun_out            (overrun_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// The ratio is only changed while reset is held, so every run starts clean.
	task automatic do_reset(input logic [1:0] pat, input logic [15:0] ratio);
		@(posedge mclk_in);
		nrst_in <= 1'b0;
		pattern <= pat;
		decimation_ratio_in <= ratio;
		sample_ready_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
	endtask

	task automatic get_word(output logic [15:0] w);
		int n;
		w = 16'hxxxx;
		for (n = 0; n < 40000; n++)
		begin
			@(posedge mclk_in);
			if (sample_valid_out === 1'b1 && sample_ready_in === 1'b1)
			begin
				w = sample_data_out;
				return;
			end
		end
		n_mismatch++;
		$display("BAD word wait expected valid seen timeout");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		do_reset(2'h0, RATIO_32);
		check("reset flags", 16'h0002, {11'h0, sample_valid_out, word_valid_out,
			word_strobe_out, fifo_space_out, overrun_out});
		check("reset data", WORD_ZERO, sample_data_out);
		$display("Test reset done");
	endtask

	// The first words after reset are settling values and are skipped.
	task automatic t_stream(input logic [1:0] pat, input logic [15:0] ratio,
		input logic [15:0] exp);
		logic [15:0] w;
		int          k;
		do_reset(pat, ratio);
		for (k = 0; k < 7; k++)
		begin
			get_word(w);
			if (k >= 5)
				check("result word", exp, w);
		end
		$display("Test stream pattern %0d ratio %0d done", pat, ratio);
	endtask

	task automatic t_timing(input int ratio);
		int   n;
		int   first;
		int   second;
		int   width;
		int   shi;
		logic prev;
		first = -1;
		second = -1;
		width = 0;
		shi = 0;
		prev = 1'b1;
		for (n = 0; n < 24 * ratio; n++)
		begin
			@(posedge mclk_in);
			if (word_valid_out === 1'b1 && prev !== 1'b1)
			begin
				if (first < 0)
					first = n;
				else if (second < 0)
					second = n;
			end
			if (first >= 0 && second < 0)
			begin
				if (word_valid_out === 1'b1)
					width++;
				if (word_strobe_out === 1'b1)
					shi++;
			end
			prev = word_valid_out;
		end
		check("word spacing", 16'(8 * ratio), 16'(second - first));
		check("valid width", 16'h0001, 16'(width));
		check("strobe high", 16'(4 * ratio), 16'(shi));
		$display("Test timing ratio %0d done", ratio);
	endtask

	// With the consumer stalled, 16 FIFO words and one output word fit; later ones drop.
	task automatic t_overrun();
		int   n;
		int   got;
		logic prev;
		do_reset(2'h2, RATIO_32);
		sample_ready_in <= 1'b0;
		repeat (22 * 256) @(posedge mclk_in);
		check("full flags", 16'h0001, {14'h0, fifo_space_out, overrun_out});
		prev = 1'b0;
		for (n = 0; n < 300 && !(prev === 1'b1 && word_strobe_out === 1'b0); n++)
		begin
			prev = word_strobe_out;
			@(posedge mclk_in);
		end
		repeat (4) @(posedge mclk_in);
		sample_ready_in <= 1'b1;
		got = 0;
		for (n = 0; n < 120; n++)
		begin
			@(posedge mclk_in);
			if (sample_valid_out === 1'b1 && sample_ready_in === 1'b1)
				got++;
		end
		check("drained words", 16'h0011, 16'(got));
		check("sticky overrun", 16'h0003, {14'h0, fifo_space_out, overrun_out});
		$display("Test overrun done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		nrst_in = 1'b0;
		sample_ready_in = 1'b1;
		decimation_ratio_in = RATIO_32;
		pattern = 2'h0;
		n_mismatch = 0;
		tests_run = 0;
		t_reset();
		t_stream(2'h0, RATIO_32, WORD_ZERO);
		t_timing(32);
		t_stream(2'h1, RATIO_32, WORD_FULL);
		t_stream(2'h1, RATIO_64, WORD_FULL);
		t_stream(2'h2, RATIO_32, 16'h8000);
		t_stream(2'h2, RATIO_64, 16'h8000);
		t_stream(2'h2, RATIO_128, 16'h8000);
		t_stream(2'h2, RATIO_256, 16'h8000);
		t_stream(2'h2, 16'h0030, 16'h00d8);
		t_timing(48);
		t_overrun();
		close_out();
	end

	initial
	begin
		#600000;
		n_mismatch++;
		$display("BAD watchdog expected end seen timeout");
		close_out();
	end

endmodule // sinc3_decimation_filter_tb
